//--- logic/ddrpc_ctrl.sv
// DDR2 command and clock-enable sequencer, host side, with Avalon-MM slave.
// Assumes a 25 MHz clk_sys that also clocks the memory and synchronous inputs.
// Behaviour
// - Commands are encoded on select, row, column, write strobes and clock enable.
// - Only deselect or no-op on power-down entry and exit edges.
// - Only deselect or no-op on the self-refresh exit edge.
// - Only deselect or no-op throughout the non-read self-refresh exit delay.
// - No read until 200 clocks after self-refresh exit.
// - No power-down or self refresh while an operation is in progress.
// - Hold each new clock-enable level for at least three edges.
// - Power-down does not refresh, so its duration is limited.
// - Clock enable stays high during output-driver calibration. The code only refuses power-down and self-refresh entry while it is set.
// - No termination in self refresh; drive termination validly in power-down.
// - Produce only legal state and command sequences.
// - Load mode registers only with all banks idle, then wait load delay.
// - A row stays open until precharge; precharge before another row.
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module ddrpc_ctrl (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Memory command pins
  output logic             mem_cke,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic      [1:0]  mem_ba,
  output logic      [12:0] mem_a,
  output logic             termination_control_input,
  output logic      [1:0]  write_mask_input
);

  ddrpc_pkg::ddrpc_regs_t s_q;
  ddrpc_pkg::ddrpc_regs_t s_d;

  logic        take;
  logic        cmd_go;
  logic [3:0]  op;
  logic [1:0]  ba;
  logic        ap;
  logic [12:0] addr;
  logic        all_idle;
  logic        mem_we;
  logic [12:0] row_rd;
  logic [7:0]  rcd_wait;

  // Row remembered per bank, read back through the row register
  ddrpc_row_mem u_row_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .we      (mem_we),
    .waddr   (ba),
    .wdata   (addr),
    .raddr   (s_q.row_sel),
    .rdata_q (row_rd)
  );

  // Field extraction from the command word
  assign op       = avs_writedata[ddrpc_pkg::CMD_OP_LSB +: 4];
  assign ba       = avs_writedata[ddrpc_pkg::CMD_BA_LSB +: 2];
  assign ap       = avs_writedata[ddrpc_pkg::CMD_AP_BIT];
  assign addr     = avs_writedata[ddrpc_pkg::CMD_ADDR_LSB +: 13];
  assign all_idle = (s_q.bank_open == 4'h0);
  assign take     = avs_write && !s_q.waitreq;
  assign cmd_go   = take && (avs_address == ddrpc_pkg::REG_CMD);
  assign mem_we   = cmd_go && (s_q.state == ddrpc_pkg::S_IDLE) && (op == ddrpc_pkg::OP_ACT)
                    && !s_q.bank_open[ba];
  // Additive latency lets a read follow activate sooner
  assign rcd_wait = (ddrpc_pkg::RCD_CLK > 8'(s_q.additive_latency))
                    ? ddrpc_pkg::RCD_CLK - 8'(s_q.additive_latency) : 8'h01;

  // Next-state logic: bus slave, counters, command sequencer
  always_comb begin
    s_d = s_q;
    // Pins fall back to no-op each cycle; only one edge carries a command
    s_d.pins.cmd = ddrpc_pkg::CMD_NOP;
    if (s_q.cnt != 8'h00) s_d.cnt = s_q.cnt - 8'h01;
    if (s_q.cke_cnt != 2'h0) s_d.cke_cnt = s_q.cke_cnt - 2'h1;
    if (s_q.xsrd_cnt != 8'h00) s_d.xsrd_cnt = s_q.xsrd_cnt - 8'h01;

    // Slave answers one cycle after the request appears
    s_d.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          ddrpc_pkg::REG_CFG: begin
            s_d.rdata[ddrpc_pkg::CFG_ODT_LVL]      = s_q.odt_lvl;
            s_d.rdata[ddrpc_pkg::CFG_ODT_EN]       = s_q.odt_en;
            s_d.rdata[ddrpc_pkg::CFG_DM_LSB +: 2]  = s_q.pins.write_mask_input;
            s_d.rdata[ddrpc_pkg::CFG_OCD]          = s_q.output_driver_calibration;
            s_d.rdata[ddrpc_pkg::CFG_AL_LSB +: 3]  = s_q.additive_latency;
            s_d.rdata[ddrpc_pkg::CFG_SEL_LSB +: 2] = s_q.row_sel;
          end
          ddrpc_pkg::REG_STATUS: begin
            s_d.rdata[ddrpc_pkg::ST_BUSY]         = (s_q.state == ddrpc_pkg::S_WAIT);
            s_d.rdata[ddrpc_pkg::ST_PD]           = (s_q.state == ddrpc_pkg::S_PD);
            s_d.rdata[ddrpc_pkg::ST_SR]           = (s_q.state == ddrpc_pkg::S_SR);
            s_d.rdata[ddrpc_pkg::ST_OPEN_LSB +: 4] = s_q.bank_open;
            s_d.rdata[ddrpc_pkg::ST_ERR]          = s_q.err;
            s_d.rdata[ddrpc_pkg::ST_RDHOLD]       = (s_q.xsrd_cnt != 8'h00);
            s_d.rdata[ddrpc_pkg::ST_CKE]          = s_q.pins.cke;
          end
          ddrpc_pkg::REG_ROW: s_d.rdata[12:0] = row_rd;
          default: ;
        endcase
      end
    end

    // Register writes: config and error clear
    if (take && avs_address == ddrpc_pkg::REG_CFG) begin
      s_d.odt_lvl               = avs_writedata[ddrpc_pkg::CFG_ODT_LVL];
      s_d.odt_en                = avs_writedata[ddrpc_pkg::CFG_ODT_EN];
      s_d.pins.write_mask_input = avs_writedata[ddrpc_pkg::CFG_DM_LSB +: 2];
      s_d.output_driver_calibration                   = avs_writedata[ddrpc_pkg::CFG_OCD];
      s_d.additive_latency      = avs_writedata[ddrpc_pkg::CFG_AL_LSB +: 3];
      s_d.row_sel               = avs_writedata[ddrpc_pkg::CFG_SEL_LSB +: 2];
    end
    if (take && avs_address == ddrpc_pkg::REG_STATUS && avs_writedata[ddrpc_pkg::ST_ERR]) begin
      s_d.err = 1'b0;
    end

    // Sequencer; any refused command sets the sticky error after the clear
    unique case (s_q.state)
      ddrpc_pkg::S_IDLE: begin
        if (cmd_go) begin
          unique case (op)
            ddrpc_pkg::OP_NOP: ;
            ddrpc_pkg::OP_MRS: begin
              if (all_idle) begin
                s_d.pins.cmd = ddrpc_pkg::CMD_MRS;
                s_d.pins.ba  = ba;
                s_d.pins.a   = addr;
                s_d.cnt      = ddrpc_pkg::MRD_CLK - 8'h01;
                s_d.state    = ddrpc_pkg::S_WAIT;
              end else begin
                s_d.err = 1'b1;
              end
            end
            ddrpc_pkg::OP_ACT: begin
              if (!s_q.bank_open[ba]) begin
                s_d.pins.cmd      = ddrpc_pkg::CMD_ACT;
                s_d.pins.ba       = ba;
                s_d.pins.a        = addr;
                s_d.bank_open[ba] = 1'b1;
                s_d.cnt           = rcd_wait - 8'h01;
                s_d.state         = ddrpc_pkg::S_WAIT;
              end else begin
                s_d.err = 1'b1;
              end
            end
            ddrpc_pkg::OP_READ: begin
              if (s_q.bank_open[ba] && s_q.xsrd_cnt == 8'h00) begin
                s_d.pins.cmd = ddrpc_pkg::CMD_READ;
                s_d.pins.ba  = ba;
                s_d.pins.a   = {2'b00, ap, addr[9:0]};
                if (ap) begin
                  s_d.bank_open[ba] = 1'b0;
                  s_d.cnt = ddrpc_pkg::BURST_CLK + 8'(s_q.additive_latency)
                            + ddrpc_pkg::RP_CLK - 8'h01;
                end else begin
                  s_d.cnt = ddrpc_pkg::BURST_CLK + 8'(s_q.additive_latency) - 8'h01;
                end
                s_d.state = ddrpc_pkg::S_WAIT;
              end else begin
                s_d.err = 1'b1;
              end
            end
            ddrpc_pkg::OP_PRE: begin
              s_d.pins.cmd = ddrpc_pkg::CMD_PRE;
              s_d.pins.ba  = ba;
              s_d.pins.a   = {2'b00, ap, 10'h000};
              if (ap) begin
                s_d.bank_open = 4'h0;
              end else begin
                s_d.bank_open[ba] = 1'b0;
              end
              s_d.cnt   = ddrpc_pkg::RP_CLK - 8'h01;
              s_d.state = ddrpc_pkg::S_WAIT;
            end
            ddrpc_pkg::OP_REF: begin
              if (all_idle) begin
                s_d.pins.cmd = ddrpc_pkg::CMD_REF;
                s_d.cnt      = ddrpc_pkg::RFC_CLK - 8'h01;
                s_d.state    = ddrpc_pkg::S_WAIT;
              end else begin
                s_d.err = 1'b1;
              end
            end
            ddrpc_pkg::OP_PD_ENTER: begin
              // Idle state means nothing is in progress here
              if (!s_q.output_driver_calibration && s_q.cke_cnt == 2'h0) begin
                s_d.pins.cke = 1'b0;
                s_d.cke_cnt  = ddrpc_pkg::CKE_MIN_CLK;
                s_d.pd_cnt   = ddrpc_pkg::PD_MAX_CLK;
                s_d.state    = ddrpc_pkg::S_PD;
              end else begin
                s_d.err = 1'b1;
              end
            end
            ddrpc_pkg::OP_SR_ENTER: begin
              if (all_idle && !s_q.output_driver_calibration && s_q.cke_cnt == 2'h0) begin
                s_d.pins.cke = 1'b0;
                s_d.pins.cmd = ddrpc_pkg::CMD_REF;
                s_d.cke_cnt  = ddrpc_pkg::CKE_MIN_CLK;
                s_d.state    = ddrpc_pkg::S_SR;
              end else begin
                s_d.err = 1'b1;
              end
            end
            default: s_d.err = 1'b1;
          endcase
        end
      end
      ddrpc_pkg::S_WAIT: begin
        // Busy: commands are refused until the delay runs out
        if (cmd_go) s_d.err = 1'b1;
        if (s_q.cnt == 8'h00) s_d.state = ddrpc_pkg::S_IDLE;
      end
      ddrpc_pkg::S_PD: begin
        // Forced exit keeps the array within its refresh interval
        if (s_q.pd_cnt != 8'h00) s_d.pd_cnt = s_q.pd_cnt - 8'h01;
        if (cmd_go && op != ddrpc_pkg::OP_EXIT) s_d.err = 1'b1;
        if (s_q.cke_cnt == 2'h0 && ((cmd_go && op == ddrpc_pkg::OP_EXIT)
                                    || s_q.pd_cnt == 8'h00)) begin
          s_d.pins.cke = 1'b1;
          s_d.cke_cnt  = ddrpc_pkg::CKE_MIN_CLK;
          s_d.state    = ddrpc_pkg::S_IDLE;
        end else if (cmd_go && op == ddrpc_pkg::OP_EXIT) begin
          s_d.err = 1'b1;
        end
      end
      ddrpc_pkg::S_SR: begin
        if (cmd_go && op == ddrpc_pkg::OP_EXIT && s_q.cke_cnt == 2'h0) begin
          s_d.pins.cke = 1'b1;
          s_d.cke_cnt  = ddrpc_pkg::CKE_MIN_CLK;
          s_d.cnt      = ddrpc_pkg::XSNR_CLK - 8'h01;
          s_d.xsrd_cnt = ddrpc_pkg::XSRD_CLK;
          s_d.state    = ddrpc_pkg::S_WAIT;
        end else if (cmd_go) begin
          s_d.err = 1'b1;
        end
      end
      default: s_d.state = ddrpc_pkg::S_IDLE;
    endcase

    // Termination off in self refresh, otherwise always a defined level
    s_d.pins.termination_control_input = (s_d.state == ddrpc_pkg::S_SR) ? 1'b0 :
                                         (s_d.odt_en & s_d.odt_lvl);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q                       <= '0;
      s_q.state                 <= ddrpc_pkg::S_IDLE;
      s_q.pins.cke              <= 1'b1;
      s_q.pins.cmd              <= ddrpc_pkg::CMD_NOP;
      s_q.waitreq               <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata              = s_q.rdata;
  assign avs_waitrequest           = s_q.waitreq;
  assign mem_cke                   = s_q.pins.cke;
  assign mem_cs_n                  = s_q.pins.cmd.cs_n;
  assign mem_ras_n                 = s_q.pins.cmd.ras_n;
  assign mem_cas_n                 = s_q.pins.cmd.cas_n;
  assign mem_we_n                  = s_q.pins.cmd.we_n;
  assign mem_ba                    = s_q.pins.ba;
  assign mem_a                     = s_q.pins.a;
  assign termination_control_input = s_q.pins.termination_control_input;
  assign write_mask_input          = s_q.pins.write_mask_input;

endmodule // ddrpc_ctrl

//--- logic/ddrpc_pkg.sv
// Package for the DDR2 power-state and command sequencer (host side).
// Assumes a 25 MHz system clock; nanosecond timing counts are derived from it here.
package ddrpc_pkg;

  // Clock period in ns
  localparam int CLK_NS = 40;

  // Timing in their own units, then cycle counts (least times round up)
  localparam int CKE_MIN_CLK_I = 3;
  localparam int XSRD_CLK_I    = 200;
  localparam int XSNR_NS       = 200;
  localparam int MRD_CLK_I     = 2;
  localparam int RCD_NS        = 15;
  localparam int RP_NS         = 15;
  localparam int RFC_NS        = 75;
  localparam int BURST_CLK_I   = 4;
  localparam int REFI_NS       = 7800;

  localparam int XSNR_CLK_I = (XSNR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CLK_I  = (RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CLK_I   = (RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RFC_CLK_I  = (RFC_NS + CLK_NS - 1) / CLK_NS;
  // Longest stay in power-down: rounds down
  localparam int PD_MAX_CLK_I = REFI_NS / CLK_NS;

  localparam logic [1:0] CKE_MIN_CLK = 2'(CKE_MIN_CLK_I - 1);
  localparam logic [7:0] XSRD_CLK    = 8'(XSRD_CLK_I);
  localparam logic [7:0] XSNR_CLK    = 8'(XSNR_CLK_I);
  localparam logic [7:0] MRD_CLK     = 8'(MRD_CLK_I);
  localparam logic [7:0] RCD_CLK     = 8'(RCD_CLK_I);
  localparam logic [7:0] RP_CLK      = 8'(RP_CLK_I);
  localparam logic [7:0] RFC_CLK     = 8'(RFC_CLK_I);
  localparam logic [7:0] BURST_CLK   = 8'(BURST_CLK_I);
  localparam logic [7:0] PD_MAX_CLK  = 8'(PD_MAX_CLK_I);

  // Register byte offsets
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_CFG    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ROW    = 4'hC;

  // Command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BA_LSB   = 4;
  localparam int CMD_AP_BIT   = 6;
  localparam int CMD_ADDR_LSB = 16;

  // Config register fields
  localparam int CFG_ODT_LVL = 0;
  localparam int CFG_ODT_EN  = 1;
  localparam int CFG_DM_LSB  = 2;
  localparam int CFG_OCD     = 4;
  localparam int CFG_AL_LSB  = 5;
  localparam int CFG_SEL_LSB = 8;

  // Status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_PD       = 1;
  localparam int ST_SR       = 2;
  localparam int ST_OPEN_LSB = 4;
  localparam int ST_ERR      = 8;
  localparam int ST_RDHOLD   = 9;
  localparam int ST_CKE      = 10;

  // Software operation codes
  localparam logic [3:0] OP_NOP      = 4'h0;
  localparam logic [3:0] OP_MRS      = 4'h1;
  localparam logic [3:0] OP_ACT      = 4'h2;
  localparam logic [3:0] OP_READ     = 4'h3;
  localparam logic [3:0] OP_PRE      = 4'h4;
  localparam logic [3:0] OP_REF      = 4'h5;
  localparam logic [3:0] OP_PD_ENTER = 4'h6;
  localparam logic [3:0] OP_SR_ENTER = 4'h7;
  localparam logic [3:0] OP_EXIT     = 4'h8;

  // Command strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddrpc_cmd_t;

  localparam ddrpc_cmd_t CMD_NOP  = 4'h7;
  localparam ddrpc_cmd_t CMD_MRS  = 4'h0;
  localparam ddrpc_cmd_t CMD_REF  = 4'h1;
  localparam ddrpc_cmd_t CMD_PRE  = 4'h2;
  localparam ddrpc_cmd_t CMD_ACT  = 4'h3;
  localparam ddrpc_cmd_t CMD_READ = 4'h5;

  // Everything driven toward the memory
  typedef struct packed {
    logic        cke;
    ddrpc_cmd_t  cmd;
    logic [1:0]  ba;
    logic [12:0] a;
    logic        termination_control_input;
    logic [1:0]  write_mask_input;
  } ddrpc_pins_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT,
    S_PD,
    S_SR
  } ddrpc_state_t;

  // Whole controller state
  typedef struct packed {
    ddrpc_state_t state;
    ddrpc_pins_t  pins;
    logic [7:0]   cnt;
    logic [1:0]   cke_cnt;
    logic [7:0]   pd_cnt;
    logic [7:0]   xsrd_cnt;
    logic [3:0]   bank_open;
    logic         err;
    logic         odt_lvl;
    logic         odt_en;
    logic         output_driver_calibration;
    logic [2:0]   additive_latency;
    logic [1:0]   row_sel;
    logic         waitreq;
    logic [31:0]  rdata;
  } ddrpc_regs_t;

endpackage

//--- logic/ddrpc_row_mem.sv
// Open-row memory: one row address per bank, registered read port.
// Assumes a single system clock; read data lag the address by one edge.
`timescale 1ns/1ps
module ddrpc_row_mem (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [12:0] wdata,
  // Read port
  input  wire logic [1:0]  raddr,
  output logic      [12:0] rdata_q
);

  logic [12:0] mem_q [4];

  // One storage word per bank
  for (genvar i = 0; i < 4; i++) begin : g_entry
    always_ff @(posedge clk_sys) begin
      if (we && waddr == 2'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // Registered read keeps bus timing independent of the array
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 13'h0000;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule // ddrpc_row_mem

//--- test/ddrpc_ctrl_sva.sv
// Checker for the command sequencer: pin and handshake timing.
// Assumes it is bound to ddrpc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module ddrpc_ctrl_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Avalon handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Memory pins
  input wire logic        mem_cke,
  input wire logic        mem_cs_n,
  input wire logic        mem_ras_n,
  input wire logic        mem_cas_n,
  input wire logic        mem_we_n,
  input wire logic [1:0]  mem_ba,
  input wire logic [12:0] mem_a,
  input wire logic        termination_control_input
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ddrpc_pkg::ddrpc_cmd_t cmd;
  logic                  no_operation_command;
  logic                  cke_q;
  logic                  sr_q;
  logic [3:0]            open_q;
  logic [7:0]            hold_q;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign no_operation_command = mem_cs_n || (cmd == ddrpc_pkg::CMD_NOP);
  // Shadow of banks and self refresh, rebuilt from the pins alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_q  <= 1'b1;
      sr_q   <= 1'b0;
      open_q <= 4'h0;
      hold_q <= 8'h00;
    end else begin
      cke_q <= mem_cke;
      if (cke_q && !mem_cke) sr_q <= (cmd == ddrpc_pkg::CMD_REF);
      // Loaded one short: the read is legal on the 200th edge after exit
      if (mem_cke && !cke_q && sr_q) hold_q <= 8'hC7;
      else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
      if (mem_cke && cke_q && !mem_cs_n) begin
        if (cmd == ddrpc_pkg::CMD_ACT) open_q[mem_ba] <= 1'b1;
        if (cmd == ddrpc_pkg::CMD_PRE) open_q <= mem_a[10] ? 4'h0 : open_q & ~(4'h1 << mem_ba);
        if (cmd == ddrpc_pkg::CMD_READ && mem_a[10]) open_q[mem_ba] <= 1'b0;
      end
    end
  end
  cke_rise_nop_a: assert property ($rose(mem_cke) |-> no_operation_command)
    else $error("command issued on clock enable rise");
  cke_fall_ok_a: assert property ($fell(mem_cke) |-> no_operation_command || cmd == ddrpc_pkg::CMD_REF)
    else $error("illegal command on clock enable fall");
  cke_width_a: assert property ($changed(mem_cke) |=> $stable(mem_cke) [*2])
    else $error("clock enable pulse too short");
  sr_idle_a: assert property ($fell(mem_cke) && !no_operation_command |-> open_q == 4'h0)
    else $error("self refresh entered with a bank open");
  sr_exit_quiet_a: assert property ($rose(mem_cke) && sr_q |-> no_operation_command [*5])
    else $error("command inside self refresh exit delay");
  read_hold_a: assert property (cmd == ddrpc_pkg::CMD_READ |-> hold_q == 8'h00)
    else $error("read too soon after self refresh");
  mrs_idle_a: assert property (cmd == ddrpc_pkg::CMD_MRS |-> open_q == 4'h0)
    else $error("mode load with a bank open");
  act_closed_a: assert property (cmd == ddrpc_pkg::CMD_ACT |-> !open_q[mem_ba])
    else $error("activate of an open bank");
  sr_no_term_a: assert property (sr_q && !mem_cke && !cke_q |-> !termination_control_input)
    else $error("termination driven in self refresh");
  ack_pulse_a: assert property ((avs_read || avs_write) && avs_waitrequest
                                |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest answer not one cycle");
endmodule // ddrpc_ctrl_sva

bind ddrpc_ctrl ddrpc_ctrl_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_cke(mem_cke),
  .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
  .mem_ba(mem_ba), .mem_a(mem_a), .termination_control_input(termination_control_input));

//--- test/ddrpc_mem_model.sv
// Behavioural memory device: power states, open banks, mode registers.
// Assumes pins change just after clk_sys rises; counts illegal sequences.
`timescale 1ns/1ps
module ddrpc_mem_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Pins from the controller
  input  wire logic        mem_cke,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic [1:0]  mem_ba,
  input  wire logic [12:0] mem_a,
  // State seen by the bench
  output logic      [3:0]  open_q,
  output logic             sr_q,
  output logic             pd_q,
  output logic      [7:0]  bad_q
);
  ddrpc_pkg::ddrpc_cmd_t cmd;
  logic                  cke_q;
  logic [12:0]           mr_q [4];
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  // Actions judged on previous and present clock enable together
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_q  <= 1'b1;
      open_q <= 4'h0;
      sr_q   <= 1'b0;
      pd_q   <= 1'b0;
      bad_q  <= 8'h00;
    end else begin
      cke_q <= mem_cke;
      if (!cke_q && mem_cke) begin
        sr_q <= 1'b0;
        pd_q <= 1'b0;
        if (!mem_cs_n && cmd != ddrpc_pkg::CMD_NOP) bad_q <= bad_q + 8'h01;
      end else if (cke_q && !mem_cke) begin
        if (cmd == ddrpc_pkg::CMD_REF && open_q == 4'h0) sr_q <= 1'b1;
        else if (mem_cs_n || cmd == ddrpc_pkg::CMD_NOP) pd_q <= 1'b1;
        else bad_q <= bad_q + 8'h01;
      end else if (mem_cke && !mem_cs_n) begin // Deselect starts nothing
        if ((cmd == ddrpc_pkg::CMD_ACT) == open_q[mem_ba] && cmd inside {ddrpc_pkg::CMD_ACT,
            ddrpc_pkg::CMD_READ}) bad_q <= bad_q + 8'h01;
        case (cmd)
          ddrpc_pkg::CMD_MRS: mr_q[mem_ba] <= mem_a;
          ddrpc_pkg::CMD_ACT: open_q[mem_ba] <= 1'b1;
          ddrpc_pkg::CMD_PRE: open_q <= mem_a[10] ? 4'h0 : open_q & ~(4'h1 << mem_ba);
          ddrpc_pkg::CMD_READ: if (mem_a[10]) open_q[mem_ba] <= 1'b0;
          default: ; // No-op leaves work running
        endcase
      end // Both levels low: pins ignored
    end
  end
endmodule // ddrpc_mem_model

//--- test/test_ddrpc_ctrl.sv
// Self-checking bench for ddrpc_ctrl with a device model on its pins.
// Assumes the register map and busy timing of the sequencer package.
`timescale 1ns/1ps
module test_ddrpc_ctrl;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, s;
  logic        avs_waitrequest, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [1:0]  mem_ba, write_mask_input;
  logic [12:0] mem_a;
  logic        termination_control_input, sr_q, pd_q;
  logic [3:0]  open_q;
  logic [7:0]  bad_q;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #20 clk_sys = ~clk_sys;
  ddrpc_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_a(mem_a), .termination_control_input(termination_control_input),
    .write_mask_input(write_mask_input));
  ddrpc_mem_model model (.clk_sys(clk_sys), .rst_n(rst_n), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_a(mem_a), .open_q(open_q), .sr_q(sr_q), .pd_q(pd_q), .bad_q(bad_q));
  task automatic complete_run;
    $display("errors %0d of %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    if (!wr) s = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Command write, then busy polled so the next order is not refused
  task automatic cmd(input logic [3:0] op, input logic [1:0] ba, input logic ap,
                     input logic [12:0] adr);
    bus(1'b1, ddrpc_pkg::REG_CMD, {3'h0, adr, 9'h000, ap, ba, op});
    do bus(1'b0, ddrpc_pkg::REG_STATUS, 32'h0); while (s[0] !== 1'b0);
  endtask
  // Error flag compared, then cleared
  task automatic err(input logic exp);
    check(32'(s[8]), 32'(exp));
    bus(1'b1, ddrpc_pkg::REG_STATUS, 32'h100);
  endtask
  task automatic t_reset;
    check(32'({mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), 32'h17);
    bus(1'b0, 4'h2, 32'h0);
    check(s, 32'h0);
  endtask
  task automatic t_rows;
    cmd(ddrpc_pkg::OP_MRS, 2'h1, 1'b0, 13'h0044);
    check(32'(model.mr_q[1]), 32'h44);
    cmd(ddrpc_pkg::OP_ACT, 2'h2, 1'b0, 13'h1ABC);
    bus(1'b1, ddrpc_pkg::REG_CFG, 32'h200);
    bus(1'b0, ddrpc_pkg::REG_ROW, 32'h0);
    check(s, 32'h1ABC);
    check(32'(open_q), 32'h4);
    cmd(ddrpc_pkg::OP_MRS, 2'h0, 1'b0, 13'h0);
    err(1'b1);
    cmd(ddrpc_pkg::OP_ACT, 2'h2, 1'b0, 13'h1);
    err(1'b1);
    cmd(ddrpc_pkg::OP_READ, 2'h1, 1'b0, 13'h0);
    err(1'b1);
    cmd(ddrpc_pkg::OP_READ, 2'h2, 1'b1, 13'h10);
    err(1'b0);
    check(32'(open_q), 32'h0);
  endtask
  task automatic t_power;
    cmd(ddrpc_pkg::OP_ACT, 2'h0, 1'b0, 13'h5);
    cmd(ddrpc_pkg::OP_PD_ENTER, 2'h0, 1'b0, 13'h0);
    check(32'({mem_cke, pd_q, open_q[0]}), 32'h3);
    cmd(ddrpc_pkg::OP_ACT, 2'h1, 1'b0, 13'h0);
    err(1'b1);
    check(32'(mem_cke), 32'h0);
    cmd(ddrpc_pkg::OP_EXIT, 2'h0, 1'b0, 13'h0);
    check(32'({mem_cke, pd_q}), 32'h2);
    cmd(ddrpc_pkg::OP_PRE, 2'h0, 1'b1, 13'h0400);
    cmd(ddrpc_pkg::OP_PD_ENTER, 2'h0, 1'b0, 13'h0);
    check(32'(mem_cke), 32'h0);
    repeat (ddrpc_pkg::PD_MAX_CLK_I + 10) @(posedge clk_sys);
    check(32'(mem_cke), 32'h1);
  endtask
  task automatic t_selfref;
    bus(1'b1, ddrpc_pkg::REG_CFG, 32'h3);
    cmd(ddrpc_pkg::OP_ACT, 2'h1, 1'b0, 13'h0);
    cmd(ddrpc_pkg::OP_SR_ENTER, 2'h0, 1'b0, 13'h0);
    err(1'b1);
    cmd(ddrpc_pkg::OP_PRE, 2'h1, 1'b0, 13'h0);
    cmd(ddrpc_pkg::OP_SR_ENTER, 2'h0, 1'b0, 13'h0);
    check(32'({mem_cke, sr_q, termination_control_input}), 32'h2);
    cmd(ddrpc_pkg::OP_EXIT, 2'h0, 1'b0, 13'h0);
    cmd(ddrpc_pkg::OP_ACT, 2'h3, 1'b0, 13'h7);
    cmd(ddrpc_pkg::OP_READ, 2'h3, 1'b0, 13'h0);
    err(1'b1);
    check(32'(s[9]), 32'h1);
    repeat (ddrpc_pkg::XSRD_CLK_I) @(posedge clk_sys);
    cmd(ddrpc_pkg::OP_READ, 2'h3, 1'b1, 13'h0);
    err(1'b0);
    check(32'({mem_cke, termination_control_input}), 32'h3);
  endtask
  task automatic t_cfg;
    bus(1'b1, ddrpc_pkg::REG_CFG, 32'h7C);
    bus(1'b0, ddrpc_pkg::REG_CFG, 32'h0);
    check(32'({s[7:2], write_mask_input}), 32'h7F);
    cmd(ddrpc_pkg::OP_PD_ENTER, 2'h0, 1'b0, 13'h0);
    err(1'b1);
    check(32'(mem_cke), 32'h1);
    cmd(4'hF, 2'h0, 1'b0, 13'h0);
    err(1'b1);
    bus(1'b1, ddrpc_pkg::REG_CFG, 32'h0);
  endtask
  // Hang guard far above the run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_rows();
    t_power();
    t_selfref();
    t_cfg();
    check(32'(bad_q), 32'h0);
    complete_run();
  end
endmodule // test_ddrpc_ctrl
